// [common/pas_cfg.svh]
// pas_cfg.svh: register indices, field positions, reset values and times
// assumes: included by bare name; defines only, no logic
`ifndef PAS_CFG_SVH
`define PAS_CFG_SVH

// management indices
`define PAS_IDX_LPA 5'h05
`define PAS_IDX_EXP 5'h06
`define PAS_IDX_NLP 5'h10
`define PAS_IDX_MODE 5'h11

// partner ability fields
`define PAS_LPA_ACK 14
`define PAS_LPA_RF 13
`define PAS_LPA_PAU_HI 11
`define PAS_LPA_PAU_LO 10
`define PAS_LPA_T4 9
`define PAS_LPA_TEC_HI 8
`define PAS_LPA_TEC_LO 5
`define PAS_LPA_SEL_HI 4
`define PAS_LPA_RST 16'h0001
`define PAS_LCW_NP 15

// expansion fields
`define PAS_EXP_PDF 4
`define PAS_EXP_LPNP 3
`define PAS_EXP_NP 2
`define PAS_EXP_PR 1
`define PAS_EXP_LPAN 0

// link-pulse control fields
`define PAS_NLP_TXEN 15
`define PAS_NLP_TXIV_HI 14
`define PAS_NLP_TXIV_LO 13
`define PAS_NLP_RXWK 12
`define PAS_NLP_RXIV_HI 11
`define PAS_NLP_RXIV_LO 10
`define PAS_NLP_RST 16'h0000
`define PAS_NLP_WMASK 16'hFC03

// mode control fields
`define PAS_MODE_SLEN 13
`define PAS_MODE_EON 1
`define PAS_MODE_SLEN_RST 1'b0

// times in ms and clock rate
`define PAS_CLK_MHZ 200
`define PAS_MS_CYC (`PAS_CLK_MHZ * 1000)
`define PAS_TX_MS_0 1000
`define PAS_TX_MS_1 768
`define PAS_TX_MS_2 512
`define PAS_TX_MS_3 256
`define PAS_RX_MS_0 64
`define PAS_RX_MS_1 256
`define PAS_RX_MS_2 512
`define PAS_RX_MS_3 1000

`endif

// [common/pas_pkg.sv]
// pas_pkg: types shared by the register block and its timers
// assumes: nothing beyond the tool's package support
package pas_pkg;
  typedef enum logic [0:0] {
    PAS_AWAKE = 1'b0,
    PAS_SLEEP = 1'b1
  } pas_pwr_e;
  typedef logic [15:0] pas_word_t;
  typedef logic [31:0] pas_cnt_t;
endpackage : pas_pkg

// [common/pas_tmr_if.sv]
// pas_tmr_if: control and status of one interval timer
// assumes: ctl side and timer side share one clock
`timescale 1ns/100ps
`default_nettype none
interface pas_tmr_if;
  import pas_pkg::*;
  logic start;
  logic stop;
  pas_cnt_t limit;
  logic expired;
  logic running;
  modport ctl (output start, output stop, output limit, input expired, input running);
  modport tmr (input start, input stop, input limit, output expired, output running);
endinterface : pas_tmr_if
`default_nettype wire

// [rtl/pas_timer.sv]
// pas_timer: one-shot down counter, pulses expired after limit cycles
// assumes: start wins over stop; limit is at least one
`timescale 1ns/100ps
`default_nettype none
module pas_timer
  import pas_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  pas_tmr_if.tmr t // timer control
);
  pas_cnt_t cnt_r;
  logic run_r;
  logic exp_r;
  logic at_end;

  assign at_end = (cnt_r == 32'h00000000);
  assign t.expired = exp_r;
  assign t.running = run_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 32'h00000000;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else if (ce) begin
      exp_r <= 1'b0;
      if (t.start) begin
        cnt_r <= t.limit - 32'h00000001;
        run_r <= 1'b1;
      end else if (t.stop) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r - 32'h00000001;
        if (at_end) begin
          run_r <= 1'b0;
          exp_r <= 1'b1;
        end
      end
    end
  end
endmodule : pas_timer
`default_nettype wire

// [rtl/pas_regs.sv]
// pas_regs: partner ability, expansion and sleep link-pulse registers
// assumes: status strobes come from logic on clk; line pins are async
//
// Function
// RULE1: registers at indices 5, 6, 16
// RULE2: acknowledge bit 14 set on code word
// RULE3: bit 13 shows partner remote fault
// RULE4: bits 11:10 show partner pause ability
// RULE5: bits 8:5 show partner technologies
// RULE6: bit 9 shows partner T4 ability
// RULE7: reset reads zero except selector 00001
// RULE8: parallel detection fault latched high, bit 4
// RULE9: bit 3 partner next page able
// RULE10: bit 2 own next page reads 0
// RULE11: page received latched high, bit 1
// RULE12: bit 0 partner autoneg able, resets 0
// RULE13: bit 15 enables periodic sleep pulses
// RULE14: bits 14:13 choose pulse spacing
// RULE15: bit 12 enables single-pulse wake
// RULE16: sleep only while index 17 bit 13
// RULE17: else two pulses within window wake
// RULE18: latched flags clear on read, set wins
`timescale 1ns/100ps
`default_nettype none
`include "pas_cfg.svh"
module pas_regs
  import pas_pkg::*;
#(
  parameter pas_cnt_t MS_CYC = `PAS_MS_CYC // cycles per millisecond
)
(
  input wire logic clk, // system clock, 200 MHz
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic [4:0] reg_idx, // management register index
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // read data
  output logic reg_rvalid, // read data valid pulse
  input wire logic lcw_valid, // link code word received pulse
  input wire logic [15:0] lcw_data, // received link code word
  input wire logic an_restart, // autoneg restart, clears partner data
  input wire logic pd_fault, // parallel detection fault pulse
  input wire logic page_rx, // new page received pulse
  input wire logic partner_an_able, // partner autoneg able level
  input wire logic rx_nlp_pin, // received link pulse, async
  input wire logic energy_pin, // energy present on line, async
  output logic tx_nlp, // send one link pulse, pulse
  output logic phy_sleeping // power-down active, level
);

  // ----------------------------------------------------------------
  // line input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic rx_prev_r;
  logic rx_nlp_ev;
  logic energy_on;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      rx_prev_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= {energy_pin, rx_nlp_pin};
      sync2_r <= sync1_r;
      rx_prev_r <= sync2_r[0];
    end
  end

  assign rx_nlp_ev = sync2_r[0] & ~rx_prev_r;
  assign energy_on = sync2_r[1];

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit_lpa;
  logic hit_exp;
  logic hit_nlp;
  logic hit_mode;
  logic exp_rd;

  // RULE1 index decode
  assign hit_lpa = (reg_idx == `PAS_IDX_LPA);
  assign hit_exp = (reg_idx == `PAS_IDX_EXP);
  assign hit_nlp = (reg_idx == `PAS_IDX_NLP);
  assign hit_mode = (reg_idx == `PAS_IDX_MODE);
  assign exp_rd = reg_rd & hit_exp;

  // ----------------------------------------------------------------
  // partner ability register
  // ----------------------------------------------------------------
  pas_word_t lpa_r;
  pas_word_t lpa_nxt;
  logic lpnp_r;
  logic lpnp_nxt;

  always_comb begin
    lpa_nxt = lpa_r;
    lpnp_nxt = lpnp_r;
    if (an_restart) begin
      // RULE7 back to reset view
      lpa_nxt = `PAS_LPA_RST;
      lpnp_nxt = 1'b0;
    end else if (lcw_valid) begin
      lpa_nxt = 16'h0000;
      // RULE2 acknowledge on word
      lpa_nxt[`PAS_LPA_ACK] = 1'b1;
      // RULE3 remote fault
      lpa_nxt[`PAS_LPA_RF] = lcw_data[`PAS_LPA_RF];
      // RULE4 pause ability
      lpa_nxt[`PAS_LPA_PAU_HI:`PAS_LPA_PAU_LO] =
        lcw_data[`PAS_LPA_PAU_HI:`PAS_LPA_PAU_LO];
      // RULE6 T4 ability
      lpa_nxt[`PAS_LPA_T4] = lcw_data[`PAS_LPA_T4];
      // RULE5 technology bits
      lpa_nxt[`PAS_LPA_TEC_HI:`PAS_LPA_TEC_LO] =
        lcw_data[`PAS_LPA_TEC_HI:`PAS_LPA_TEC_LO];
      lpa_nxt[`PAS_LPA_SEL_HI:0] = lcw_data[`PAS_LPA_SEL_HI:0];
      // RULE9 partner next page
      lpnp_nxt = lcw_data[`PAS_LCW_NP];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // RULE7 reset value
      lpa_r <= `PAS_LPA_RST;
      lpnp_r <= 1'b0;
    end else if (ce) begin
      lpa_r <= lpa_nxt;
      lpnp_r <= lpnp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // expansion register
  // ----------------------------------------------------------------
  logic pdf_r;
  logic pdf_nxt;
  logic pgr_r;
  logic pgr_nxt;
  logic lpan_r;
  pas_word_t exp_view;

  // RULE8 fault latched high
  // RULE18 read clears, set wins
  assign pdf_nxt = pd_fault | (pdf_r & ~exp_rd);
  // RULE11 page latched high
  assign pgr_nxt = page_rx | (pgr_r & ~exp_rd);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pdf_r <= 1'b0;
      pgr_r <= 1'b0;
      lpan_r <= 1'b0;
    end else if (ce) begin
      pdf_r <= pdf_nxt;
      pgr_r <= pgr_nxt;
      // RULE12 partner autoneg able
      lpan_r <= partner_an_able;
    end
  end

  always_comb begin
    exp_view = 16'h0000;
    exp_view[`PAS_EXP_PDF] = pdf_r;
    exp_view[`PAS_EXP_LPNP] = lpnp_r;
    // RULE10 own next page zero
    exp_view[`PAS_EXP_NP] = 1'b0;
    exp_view[`PAS_EXP_PR] = pgr_r;
    exp_view[`PAS_EXP_LPAN] = lpan_r;
  end

  // ----------------------------------------------------------------
  // link-pulse control and mode registers
  // ----------------------------------------------------------------
  pas_word_t nlp_r;
  logic slen_r;
  logic tx_en;
  logic rx_single;
  logic [1:0] tx_sel;
  logic [1:0] rx_sel;
  pas_word_t mode_view;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nlp_r <= `PAS_NLP_RST;
      slen_r <= `PAS_MODE_SLEN_RST;
    end else if (ce) begin
      if (reg_wr && hit_nlp) begin
        nlp_r <= reg_wdata & `PAS_NLP_WMASK;
      end
      if (reg_wr && hit_mode) begin
        slen_r <= reg_wdata[`PAS_MODE_SLEN];
      end
    end
  end

  assign tx_en = nlp_r[`PAS_NLP_TXEN];
  assign tx_sel = nlp_r[`PAS_NLP_TXIV_HI:`PAS_NLP_TXIV_LO];
  assign rx_single = nlp_r[`PAS_NLP_RXWK];
  assign rx_sel = nlp_r[`PAS_NLP_RXIV_HI:`PAS_NLP_RXIV_LO];

  always_comb begin
    mode_view = 16'h0000;
    mode_view[`PAS_MODE_SLEN] = slen_r;
    mode_view[`PAS_MODE_EON] = energy_on;
  end

  // ----------------------------------------------------------------
  // interval selection
  // ----------------------------------------------------------------
  pas_cnt_t tx_ms;
  pas_cnt_t rx_ms;
  pas_cnt_t tx_limit;
  pas_cnt_t rx_limit;

  // RULE14 pulse spacing choice
  assign tx_ms = (tx_sel == 2'h0) ? 32'(`PAS_TX_MS_0) :
                 (tx_sel == 2'h1) ? 32'(`PAS_TX_MS_1) :
                 (tx_sel == 2'h2) ? 32'(`PAS_TX_MS_2) : 32'(`PAS_TX_MS_3);
  // RULE17 wake window choice
  assign rx_ms = (rx_sel == 2'h0) ? 32'(`PAS_RX_MS_0) :
                 (rx_sel == 2'h1) ? 32'(`PAS_RX_MS_1) :
                 (rx_sel == 2'h2) ? 32'(`PAS_RX_MS_2) : 32'(`PAS_RX_MS_3);
  assign tx_limit = 32'(tx_ms * MS_CYC);
  assign rx_limit = 32'(rx_ms * MS_CYC);

  // ----------------------------------------------------------------
  // power-down state machine
  // ----------------------------------------------------------------
  pas_pwr_e pwr_r;
  pas_pwr_e pwr_nxt;
  logic go_sleep;
  logic wake;
  logic first_pulse;

  pas_tmr_if tx_t ();
  pas_tmr_if rx_t ();

  // RULE16 sleep needs enable bit
  assign go_sleep = (pwr_r == PAS_AWAKE) & slen_r & ~energy_on;
  // RULE15 single pulse wakes
  // RULE17 second pulse in window
  assign wake = (pwr_r == PAS_SLEEP) & rx_nlp_ev & (rx_single | rx_t.running);
  assign first_pulse = (pwr_r == PAS_SLEEP) & rx_nlp_ev & ~wake;

  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      PAS_AWAKE: begin
        if (go_sleep) begin
          pwr_nxt = PAS_SLEEP;
        end
      end
      PAS_SLEEP: begin
        if (!slen_r || wake) begin
          pwr_nxt = PAS_AWAKE;
        end
      end
    endcase
  end

  // RULE13 periodic pulse timer
  assign tx_t.start = tx_en & ((go_sleep) |
                      ((pwr_r == PAS_SLEEP) & (tx_t.expired | ~tx_t.running)));
  assign tx_t.stop = ~tx_en | (pwr_r == PAS_AWAKE);
  assign tx_t.limit = tx_limit;

  // RULE17 first pulse opens window
  assign rx_t.start = first_pulse;
  assign rx_t.stop = (pwr_r == PAS_AWAKE);
  assign rx_t.limit = rx_limit;

  pas_timer u_tx_timer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .t(tx_t)
  );

  pas_timer u_rx_timer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .t(rx_t)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_r <= PAS_AWAKE;
      phy_sleeping <= 1'b0;
      tx_nlp <= 1'b0;
    end else if (ce) begin
      pwr_r <= pwr_nxt;
      phy_sleeping <= (pwr_nxt == PAS_SLEEP);
      // RULE13 pulse only when enabled
      tx_nlp <= tx_t.expired & tx_en & (pwr_r == PAS_SLEEP) & slen_r;
    end
  end

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  pas_word_t rd_mux;

  // RULE1 read selection
  assign rd_mux = hit_lpa ? lpa_r :
                  hit_exp ? exp_view :
                  hit_nlp ? nlp_r :
                  hit_mode ? mode_view : 16'h0000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule : pas_regs
`default_nettype wire

// [bench/pas_regs_chk.sv]
// pas_regs_chk: port timing relations of the register block
// assumes: bound into pas_regs; one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "pas_cfg.svh"
module pas_regs_chk
  import pas_pkg::*;
#(
  parameter pas_cnt_t MS_CYC = `PAS_MS_CYC // cycles per millisecond
)
(
  input wire logic clk, nrst, ce, // clock, reset, enable
  input wire logic [4:0] reg_idx, // register index
  input wire logic reg_wr, reg_rd, reg_rvalid, // strobes, answer
  input wire logic [15:0] reg_wdata, reg_rdata, lcw_data, // data
  input wire logic lcw_valid, an_restart, pd_fault, page_rx, partner_an_able, // status
  input wire logic rx_nlp_pin, energy_pin, tx_nlp, phy_sleeping // line side
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [15:0] lcw_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) lcw_q <= 16'h0000;
    else if (ce && lcw_valid) lcw_q <= lcw_data;
  end
  wire rd_take = ce && reg_rd;
  wire rd_lpa = rd_take && reg_idx == `PAS_IDX_LPA && !lcw_valid && !an_restart;
  wire rd_exp = rd_take && reg_idx == `PAS_IDX_EXP;
  wire quiet = ce && !pd_fault && !page_rx;
  wire mapped = reg_idx == `PAS_IDX_LPA || reg_idx == `PAS_IDX_EXP ||
    reg_idx == `PAS_IDX_NLP || reg_idx == `PAS_IDX_MODE;
  sequence word_read;
    (ce && lcw_valid && !an_restart) ##1 (ce && !an_restart) ##1 rd_lpa;
  endsequence
  sequence restart_read;
    (ce && an_restart) ##1 (ce && !lcw_valid) ##1 rd_lpa;
  endsequence
  sequence read_clean;
    (rd_exp && quiet) ##1 quiet ##1 (rd_exp && quiet);
  endsequence
  AST_ANSWER: assert property (reg_rvalid == $past(rd_take))
    else $error("read answer timing wrong");
  AST_UNMAP: assert property (rd_take && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped index read not zero");
  AST_ACK: assert property (word_read |=> reg_rdata[15:14] == 2'b01)
    else $error("acknowledge wrong after code word");
  AST_RF: assert property (word_read |=> reg_rdata[13] == lcw_q[13])
    else $error("remote fault bit wrong");
  AST_PAUSE: assert property (word_read |=> reg_rdata[12:10] == {1'b0, lcw_q[11:10]})
    else $error("pause field wrong");
  AST_TECH: assert property (word_read |=> reg_rdata[8:0] == lcw_q[8:0])
    else $error("technology field wrong");
  AST_T4: assert property (word_read |=> reg_rdata[9] == lcw_q[9])
    else $error("T4 bit wrong");
  AST_SEL: assert property (restart_read |=> reg_rdata == `PAS_LPA_RST)
    else $error("partner ability not back to reset value");
  AST_PDF: assert property ((ce && pd_fault) ##1 (ce && !reg_rd) ##1 rd_exp |=> reg_rdata[4])
    else $error("fault flag not latched");
  AST_OWN_NP: assert property (rd_exp |=> reg_rdata[15:5] == 11'h000 && !reg_rdata[2])
    else $error("expansion reserved or own next page set");
  AST_PR: assert property ((ce && page_rx) ##1 (ce && !reg_rd) ##1 rd_exp |=> reg_rdata[1])
    else $error("page flag not latched");
  AST_CLEAR: assert property (read_clean |=> reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0)
    else $error("latched flags not cleared by read");
  AST_TX_GATE: assert property (tx_nlp |-> $past(phy_sleeping))
    else $error("link pulse sent while awake");
endmodule : pas_regs_chk
bind pas_regs pas_regs_chk #(.MS_CYC(MS_CYC)) i_pas_regs_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .lcw_data(lcw_data), .lcw_valid(lcw_valid), .an_restart(an_restart),
  .pd_fault(pd_fault), .page_rx(page_rx), .partner_an_able(partner_an_able),
  .rx_nlp_pin(rx_nlp_pin), .energy_pin(energy_pin), .tx_nlp(tx_nlp),
  .phy_sleeping(phy_sleeping)
);
`default_nettype wire

// [bench/pas_lp_model.sv]
// pas_lp_model: line partner, sends link pulses and energy, times our pulses
// assumes: driven from the bench clock
`timescale 1ns/100ps
`default_nettype none
module pas_lp_model (
  input wire logic clk, // system clock
  input wire logic tx_nlp, // pulse sent by the block
  output logic rx_nlp_pin, // pulse toward the block
  output logic energy_pin // energy on the line
);
  int gap = 0;
  int last_gap = 0;
  int tx_count = 0;
  initial begin
    rx_nlp_pin = 1'b0;
    energy_pin = 1'b1;
  end
  // spacing of the block's pulses on tx_nlp, sampled mid-cycle once settled
  always @(negedge clk) begin
    gap <= gap + 1;
    if (tx_nlp === 1'b1) begin
      last_gap <= gap + 1;
      gap <= 0;
      tx_count <= tx_count + 1;
    end
  end
  task automatic send_pulse();
    @(posedge clk);
    #1 rx_nlp_pin = 1'b1;
    repeat (3) @(posedge clk);
    #1 rx_nlp_pin = 1'b0;
  endtask : send_pulse
endmodule : pas_lp_model
`default_nettype wire

// [bench/phy_autoneg_status_energy_detect_power_down_regs_test.sv]
// phy_autoneg_status_energy_detect_power_down_regs_test: register and power-down scenarios
// assumes: checker bound by its own file; partner model on the line pins
`timescale 1ns/100ps
`default_nettype none
module phy_autoneg_status_energy_detect_power_down_regs_test;
  localparam int MSC = 4;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic lcw_valid = 1'b0, an_restart = 1'b0, pd_fault = 1'b0, page_rx = 1'b0, an = 1'b0;
  logic [4:0] reg_idx = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, lcw_data = 16'h0000, reg_rdata, d;
  logic reg_rvalid, rx_nlp_pin, energy_pin, tx_nlp, phy_sleeping, np;
  logic [15:0] exp_q[$];
  int errors = 0, total_checks = 0, seed = 29, n;
  localparam int TX_MS[4] = '{1000, 768, 512, 256};
  always #2.5 clk = ~clk;
  pas_regs #(.MS_CYC(MSC)) i_pas_regs (.clk(clk), .nrst(nrst), .ce(ce), .reg_idx(reg_idx),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .lcw_valid(lcw_valid), .lcw_data(lcw_data),
    .an_restart(an_restart), .pd_fault(pd_fault), .page_rx(page_rx), .partner_an_able(an),
    .rx_nlp_pin(rx_nlp_pin), .energy_pin(energy_pin), .tx_nlp(tx_nlp),
    .phy_sleeping(phy_sleeping));
  pas_lp_model i_pas_lp_model (.clk(clk), .tx_nlp(tx_nlp), .rx_nlp_pin(rx_nlp_pin),
    .energy_pin(energy_pin));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] idx, input logic [15:0] v);
    @(posedge clk);
    #1 {reg_idx, reg_wdata, reg_wr} = {idx, v, 1'b1};
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] idx, input logic [15:0] e);
    @(posedge clk);
    #1 {reg_idx, reg_rd} = {idx, 1'b1};
    exp_q.push_back(e);
    @(posedge clk);
    #1 reg_rd = 1'b0;
  endtask : rd
  task automatic strobe(input int k);
    @(posedge clk);
    #1 {page_rx, pd_fault, an_restart, lcw_valid} = 4'b0001 << k;
    @(posedge clk);
    #1 {page_rx, pd_fault, an_restart, lcw_valid} = 4'b0000;
  endtask : strobe
  task automatic wait_lvl(input logic v, input int bound);
    int k;
    k = 0;
    while (phy_sleeping !== v && k < bound) begin
      @(posedge clk);
      #1 k++;
    end
    chk("power-down level", {15'h0000, v}, {15'h0000, phy_sleeping});
    if (phy_sleeping !== v) conclude();
  endtask : wait_lvl
  task automatic wait_tx();
    int k, c;
    k = 0;
    c = i_pas_lp_model.tx_count;
    while (i_pas_lp_model.tx_count == c && k < 5000) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 5000) begin
      errors++;
      conclude();
    end
  endtask : wait_tx
  // read answers against the queued notes, sampled mid-cycle once settled
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unrequested read", 16'hFFFF, reg_rdata);
      else chk("read data", exp_q.pop_front(), reg_rdata);
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    // ------------------------------------------------------------
    // reset values, read-only and unmapped places
    // ------------------------------------------------------------
    rd(5'h05, 16'h0001);
    rd(5'h06, 16'h0000);
    rd(5'h10, 16'h0000);
    rd(5'h11, 16'h0002);
    rd(5'h07, 16'h0000);
    wr(5'h05, 16'hFFFF);
    wr(5'h1F, 16'hFFFF);
    rd(5'h05, 16'h0001);
    rd(5'h1F, 16'h0000);
    d = $random(seed);
    wr(5'h10, d);
    rd(5'h10, d & 16'hFC03);
    $display("test reset done");
    // ------------------------------------------------------------
    // partner code words, restart and latched flags
    // ------------------------------------------------------------
    an = 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      lcw_data = d;
      np = d[15];
      strobe(0);
      rd(5'h05, {2'b01, d[13], 1'b0, d[11:0]});
      rd(5'h06, {12'h000, np, 3'b001});
    end
    strobe(2);
    rd(5'h06, {12'h001, np, 3'b001});
    strobe(3);
    rd(5'h06, {12'h000, np, 3'b011});
    rd(5'h06, {12'h000, np, 3'b001});
    strobe(1);
    rd(5'h05, 16'h0001);
    rd(5'h06, 16'h0001);
    $display("test status done");
    // ------------------------------------------------------------
    // power-down pulses and wake
    // ------------------------------------------------------------
    wr(5'h10, 16'h8000);
    wr(5'h11, 16'h2000);
    i_pas_lp_model.energy_pin = 1'b0;
    wait_lvl(1'b1, 20);
    rd(5'h11, 16'h2000);
    for (int c = 0; c < 4; c++) begin
      wr(5'h10, 16'h8000 | (16'(c) << 13));
      wait_tx();
      wait_tx();
      chk("pulse spacing", 16'(TX_MS[c] * MSC + 1), 16'(i_pas_lp_model.last_gap));
    end
    wr(5'h10, 16'h1000);
    n = i_pas_lp_model.tx_count;
    i_pas_lp_model.send_pulse();
    wait_lvl(1'b0, 20);
    wait_lvl(1'b1, 20);
    repeat (1200) @(posedge clk);
    chk("pulse count", 16'(n), 16'(i_pas_lp_model.tx_count));
    wr(5'h10, 16'h0000);
    i_pas_lp_model.send_pulse();
    repeat (40) @(posedge clk);
    chk("sleep after one pulse", 16'h0001, {15'h0000, phy_sleeping});
    repeat (300) @(posedge clk);
    i_pas_lp_model.send_pulse();
    repeat (40) @(posedge clk);
    chk("sleep after late pulse", 16'h0001, {15'h0000, phy_sleeping});
    i_pas_lp_model.send_pulse();
    wait_lvl(1'b0, 20);
    wr(5'h11, 16'h0000);
    repeat (10) @(posedge clk);
    chk("awake when disabled", 16'h0000, {15'h0000, phy_sleeping});
    $display("test power-down done");
    repeat (4) @(posedge clk);
    chk("reads answered", 16'h0000, 16'(exp_q.size()));
    conclude();
  end
endmodule : phy_autoneg_status_energy_detect_power_down_regs_test
`default_nettype wire
